// [src/gdr_pkg.sv]
// Purpose: Shared constants and types of the gyro data register block.
// Assumes: 16-bit serial words, 7-bit register addresses.
// Notes: Offsets are the serial address values, not byte addresses.
package gdr_pkg;

   // ***************************************************************
   // Register addresses
   // ***************************************************************
   localparam logic [6:0] GDR_ADR_RATE = 7'h00;
   localparam logic [6:0] GDR_ADR_IDENT = 7'h07;
   localparam logic [6:0] GDR_ADR_STATUS = 7'h08;
   localparam logic [6:0] GDR_ADR_FACTORY = 7'h09;
   localparam logic [6:0] GDR_ADR_TEMP = 7'h0a;

   // ***************************************************************
   // Widths and field positions
   // ***************************************************************
   localparam int GDR_WORD_W = 16;
   localparam int GDR_SAMPLE_W = 14;
   localparam int GDR_MON_W = 13;
   localparam int GDR_ADR_LSB = 3;
   localparam int GDR_ADR_MSB = 9;
   localparam int GDR_RW_BIT = 2;
   localparam int GDR_PAR_EN_BIT = 12;
   localparam int GDR_PAR_SEL_BIT = 13;
   localparam int GDR_PAR_OK_BIT = 9;
   localparam int GDR_MON_LOW_N = 7;

   // ***************************************************************
   // Frame lengths in serial clock cycles
   // ***************************************************************
   localparam logic [4:0] GDR_FRAME_PLAIN = 5'h10;
   localparam logic [4:0] GDR_FRAME_PAR = 5'h11;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic GDR_PAR_EN_RST = 1'h0;
   localparam logic GDR_PAR_SEL_RST = 1'h0;
   localparam logic GDR_PAR_OK_RST = 1'h1;
   // Pins in order chip select, serial clock, serial data in
   localparam logic [2:0] GDR_PIN_RST = 3'h4;

   typedef enum logic [0:0] {
      GDR_PH_ADDR = 1'b0,
      GDR_PH_DATA = 1'b1
   } gdr_phase_t;

endpackage

// [src/gdr_sync.sv]
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: d is asynchronous to ref_clk.
// Notes: The output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module gdr_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic q_ff;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         q_ff <= RST_VAL;
      end else if (s2_ff == s3_ff) begin
         q_ff <= s3_ff;
      end
   end

   assign q = q_ff;
endmodule
`default_nettype wire

// [src/gdr_core.sv]
// Purpose: Serial slave and data register bank of an angular-rate sensor.
// Assumes: Serial clock well below ref_clk/4; mode 0 framing, MSB first.
// Notes: Samples and monitoring flags come from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module gdr_core (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic rate_chip_select_n,
   input wire logic mosi,
   input wire logic [gdr_pkg::GDR_SAMPLE_W-1:0] rate_sample,
   input wire logic [gdr_pkg::GDR_SAMPLE_W-1:0] temp_sample,
   input wire logic [gdr_pkg::GDR_MON_W-1:0] monitor_flags,
   output logic miso,
   output logic miso_oe,
   output logic parity_enable,
   output logic parity_sense_select
);
   import gdr_pkg::*;

   // ***************************************************************
   // Pin synchronisers and edge detection
   // ***************************************************************
   logic [2:0] pin_raw;
   logic [2:0] pin_s;
   logic cs_s;
   logic sck_s;
   logic mosi_s;
   logic cs_q_ff;
   logic sck_q_ff;
   assign pin_raw = {rate_chip_select_n, sck, mosi};
   generate
      for (genvar i = 0; i < 3; i++) begin : g_pin
         gdr_sync #(
            .RST_VAL(GDR_PIN_RST[i])
         ) u_sync (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .d(pin_raw[i]),
            .q(pin_s[i])
         );
      end
   endgenerate
   assign cs_s = pin_s[2];
   assign sck_s = pin_s[1];
   assign mosi_s = pin_s[0];
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cs_q_ff <= GDR_PIN_RST[2];
         sck_q_ff <= GDR_PIN_RST[1];
      end else begin
         cs_q_ff <= cs_s;
         sck_q_ff <= sck_s;
      end
   end

   logic frame_start;
   logic sck_rise;
   logic sck_fall;
   assign frame_start = cs_q_ff & ~cs_s;
   assign sck_rise = ~cs_s & sck_s & ~sck_q_ff;
   assign sck_fall = ~cs_s & ~sck_s & sck_q_ff;

   // ***************************************************************
   // Register contents
   // ***************************************************************
   logic par_en_ff;
   logic par_sel_ff;
   logic par_ok_ff;
   logic [15:0] status_word;
   logic s_ok;
   logic [14:0] rate_body;
   logic [14:0] temp_body;
   logic [15:0] rate_word;
   logic [15:0] temp_word;
   logic [15:0] ident_word;
   logic [15:0] flags_word;
   // Parity flag sits in the middle of the monitor field, so it also gates validity
   assign status_word = {monitor_flags[GDR_MON_W-1:GDR_MON_LOW_N], par_ok_ff,
                         monitor_flags[GDR_MON_LOW_N-1:0], 2'h0};
   assign s_ok = &status_word[15:2];
   assign rate_body = {rate_sample, s_ok};
   assign temp_body = {temp_sample, s_ok};
   // Bit 15 is left out of the parity on purpose
   assign rate_word = {rate_body, ~^rate_body[13:0]};
   assign temp_word = {temp_body, ~^temp_body[13:0]};
   assign ident_word = {2'h0, par_sel_ff, par_en_ff, 12'h000};
   assign flags_word = {14'h0000, s_ok, ~s_ok};

   function automatic logic [15:0] reg_read(input logic [6:0] a);
      logic [15:0] v;
      v = 16'h0000;
      case (a)
         GDR_ADR_RATE: v = rate_word;
         GDR_ADR_IDENT: v = ident_word;
         GDR_ADR_STATUS: v = status_word;
         GDR_ADR_TEMP: v = temp_word;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // ***************************************************************
   // Receive path
   // ***************************************************************
   logic [4:0] bit_cnt_ff;
   logic [16:0] rx_sr_ff;
   logic [16:0] rx_full;
   logic [4:0] frame_last;
   logic word_done;
   logic [15:0] rx_word;
   logic perr;
   logic [6:0] rx_adr;
   logic rx_rw;
   assign frame_last = par_en_ff ? (GDR_FRAME_PAR - 5'h01) : (GDR_FRAME_PLAIN - 5'h01);
   assign word_done = sck_rise & (bit_cnt_ff == frame_last);
   assign rx_full = {rx_sr_ff[15:0], mosi_s};
   assign rx_word = par_en_ff ? rx_full[16:1] : rx_full[15:0];
   // Even sense: total ones even; odd sense: total ones odd
   assign perr = par_en_ff & ((^rx_full) != par_sel_ff);
   assign rx_adr = rx_word[GDR_ADR_MSB:GDR_ADR_LSB];
   assign rx_rw = rx_word[GDR_RW_BIT];

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bit_cnt_ff <= 5'h00;
      end else if (frame_start || word_done) begin
         bit_cnt_ff <= 5'h00;
      end else if (sck_rise) begin
         bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rx_sr_ff <= 17'h00000;
      end else if (frame_start) begin
         rx_sr_ff <= 17'h00000;
      end else if (sck_rise) begin
         rx_sr_ff <= rx_full;
      end
   end

   // ***************************************************************
   // Word sequencing
   // ***************************************************************
   gdr_phase_t phase_ff;
   logic [6:0] wr_adr_ff;
   logic addr_perr_ff;
   logic wr_ok;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         phase_ff <= GDR_PH_ADDR;
         wr_adr_ff <= 7'h00;
         addr_perr_ff <= 1'b0;
      end else if (frame_start) begin
         phase_ff <= GDR_PH_ADDR;
         addr_perr_ff <= 1'b0;
      end else if (word_done) begin
         case (phase_ff)
            GDR_PH_ADDR: begin
               // A read keeps the sequencer in address phase
               if (rx_rw) begin
                  phase_ff <= GDR_PH_DATA;
                  wr_adr_ff <= rx_adr;
                  addr_perr_ff <= perr;
               end else begin
                  phase_ff <= GDR_PH_ADDR;
               end
            end
            GDR_PH_DATA: begin
               phase_ff <= GDR_PH_ADDR;
               addr_perr_ff <= 1'b0;
            end
            default: phase_ff <= GDR_PH_ADDR;
         endcase
      end
   end

   assign wr_ok = word_done & (phase_ff == GDR_PH_DATA) & ~perr & ~addr_perr_ff;

   // Only the two parity bits are writable; factory fields are left alone
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         par_en_ff <= GDR_PAR_EN_RST;
         par_sel_ff <= GDR_PAR_SEL_RST;
      end else if (wr_ok && (wr_adr_ff == GDR_ADR_IDENT)) begin
         par_en_ff <= rx_word[GDR_PAR_EN_BIT];
         par_sel_ff <= rx_word[GDR_PAR_SEL_BIT];
      end
   end

   // Error wins over the read clear so a fault in the same word is kept
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         par_ok_ff <= GDR_PAR_OK_RST;
      end else if (word_done && perr) begin
         par_ok_ff <= 1'b0;
      end else if (word_done && (phase_ff == GDR_PH_ADDR) && !rx_rw && (rx_adr == GDR_ADR_STATUS)) begin
         par_ok_ff <= 1'b1;
      end
   end

   // ***************************************************************
   // Transmit path
   // ***************************************************************
   logic [16:0] tx_sr_ff;
   logic [15:0] tx_next_ff;
   logic tx_pend_ff;

   function automatic logic [16:0] tx_frame(input logic [15:0] w, input logic sel);
      return {w, sel ? ~^w : ^w};
   endfunction

   // Next word is captured at word end; a parity-failed read still answers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tx_next_ff <= 16'h0000;
      end else if (word_done) begin
         if (phase_ff == GDR_PH_ADDR) begin
            tx_next_ff <= reg_read(rx_adr);
         end else begin
            tx_next_ff <= flags_word;
         end
      end
   end

   // The new word is loaded at the falling edge, when the old one ends
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tx_sr_ff <= 17'h00000;
         tx_pend_ff <= 1'b0;
      end else if (frame_start) begin
         tx_sr_ff <= tx_frame(flags_word, par_sel_ff);
         tx_pend_ff <= 1'b0;
      end else if (word_done) begin
         tx_pend_ff <= 1'b1;
      end else if (sck_fall) begin
         if (tx_pend_ff) begin
            tx_sr_ff <= tx_frame(tx_next_ff, par_sel_ff);
            tx_pend_ff <= 1'b0;
         end else begin
            tx_sr_ff <= {tx_sr_ff[15:0], 1'b0};
         end
      end
   end

   assign miso = tx_sr_ff[16];
   assign miso_oe = ~cs_s;
   assign parity_enable = par_en_ff;
   assign parity_sense_select = par_sel_ff;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   property p_rate_parity;
      @(posedge ref_clk) disable iff (!rst_n)
      ^{rate_word[14:1], rate_word[0]} == 1'b1;
   endproperty
   a_rate_parity: assert property (p_rate_parity) else $error("rate parity not odd");
   property p_valid;
      @(posedge ref_clk) disable iff (!rst_n)
      (rate_word[1] == (&monitor_flags & par_ok_ff)) && (temp_word[1] == rate_word[1]);
   endproperty
   a_valid: assert property (p_valid) else $error("validity flag wrong");
   property p_temp_parity;
      @(posedge ref_clk) disable iff (!rst_n)
      (^temp_word[14:0] == 1'b1) && (temp_word[15:2] == temp_sample);
   endproperty
   a_temp_parity: assert property (p_temp_parity) else $error("temperature word wrong");
   property p_rate_load;
      @(posedge ref_clk) disable iff (!rst_n)
      word_done && (phase_ff == GDR_PH_ADDR) && (rx_adr == GDR_ADR_RATE)
      |=> tx_next_ff[15:2] == $past(rate_sample);
   endproperty
   a_rate_load: assert property (p_rate_load) else $error("rate sample not returned");
   property p_unmapped;
      @(posedge ref_clk) disable iff (!rst_n)
      word_done && (phase_ff == GDR_PH_ADDR) && ((rx_adr > GDR_ADR_TEMP) ||
      ((rx_adr > GDR_ADR_RATE) && (rx_adr < GDR_ADR_IDENT)) || (rx_adr == GDR_ADR_FACTORY))
      |=> tx_next_ff == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped address not zero");
   property p_perr_flag;
      @(posedge ref_clk) disable iff (!rst_n)
      word_done && perr |=> !par_ok_ff && (status_word[GDR_PAR_OK_BIT] == 1'b0);
   endproperty
   a_perr_flag: assert property (p_perr_flag) else $error("parity error not flagged");
   property p_read_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      word_done && !perr && (phase_ff == GDR_PH_ADDR) && !rx_rw && (rx_adr == GDR_ADR_STATUS)
      |=> par_ok_ff;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("status read did not clear");
   property p_cancel;
      @(posedge ref_clk) disable iff (!rst_n)
      word_done && (phase_ff == GDR_PH_DATA) && (perr || addr_perr_ff)
      |=> $stable(par_en_ff) && $stable(par_sel_ff);
   endproperty
   a_cancel: assert property (p_cancel) else $error("failed write changed config");
   property p_write;
      @(posedge ref_clk) disable iff (!rst_n)
      wr_ok && (wr_adr_ff == GDR_ADR_IDENT)
      |=> (par_en_ff == $past(rx_word[GDR_PAR_EN_BIT])) && (par_sel_ff == $past(rx_word[GDR_PAR_SEL_BIT]));
   endproperty
   a_write: assert property (p_write) else $error("config write lost");
   property p_frame_len;
      @(posedge ref_clk) disable iff (!rst_n)
      word_done |-> (bit_cnt_ff == (par_en_ff ? 5'h10 : 5'h0f));
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
   property p_after_read;
      @(posedge ref_clk) disable iff (!rst_n)
      word_done && (phase_ff == GDR_PH_ADDR) && !rx_rw |=> (phase_ff == GDR_PH_ADDR) && tx_pend_ff;
   endproperty
   a_after_read: assert property (p_after_read) else $error("read not followed by address");
endmodule
`default_nettype wire

// [tb/gdr_host_model.sv]
// Purpose: Host-side serial master model that drives frames into the gyro data register block.
// Assumes: Mode 0, MSB first, sck half period of four ref_clk cycles (400 ns period).
// Notes: miso is taken at the end of the high phase, which leaves room for the pin synchronisers.
`timescale 1ns/1ps
`default_nettype none
module gdr_host_model (
   input wire logic ref_clk,
   input wire logic miso,
   output logic sck,
   output logic rate_chip_select_n,
   output logic mosi
);
   initial begin
      sck = 1'b0;
      rate_chip_select_n = 1'b1;
      mosi = 1'b0;
   end

   task automatic half();
      repeat (4) @(negedge ref_clk);
   endtask

   task automatic open_cs();
      rate_chip_select_n = 1'b0;
      half();
      half();
   endtask

   // ***************************************************************
   // One word, plus a parity bit in parity mode; flip corrupts it
   // ***************************************************************
   task automatic xword(input logic [15:0] w, input logic pen, input logic psel, input logic flip,
                        output logic [16:0] r);
      logic [16:0] bits;
      int n;
      bits = {w, (psel ? ~^w : ^w) ^ flip};
      n = pen ? 17 : 16;
      r = '0;
      for (int i = 16; i > 16 - n; i--) begin
         mosi = bits[i];
         half();
         sck = 1'b1;
         half();
         r = {r[15:0], miso};
         sck = 1'b0;
      end
   endtask

   task automatic close_cs();
      half();
      rate_chip_select_n = 1'b1;
      // Deselected line must not keep looking valid
      mosi = ~mosi;
      half();
      half();
   endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the gyro data register block.
// Assumes: Host model drives all serial pins; samples change only at ref_clk falling edges.
// Notes: Expected words are rebuilt from the sample, monitor and parity-state mirrors.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("unexpected %s expected %h seen %h", nm, (e), (g)); \
   end \
end
module testbench;
   import gdr_pkg::*;
   logic ref_clk;
   logic rst_n;
   logic sck;
   logic rate_chip_select_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic parity_enable;
   logic parity_sense_select;
   logic [13:0] rate_s;
   logic [13:0] temp_s;
   logic [12:0] mon;
   logic pok;
   logic en;
   logic sel;
   logic [6:0] aq[$];
   int bad_count;
   int comparisons;

   gdr_core dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .rate_chip_select_n(rate_chip_select_n),
      .mosi(mosi), .rate_sample(rate_s), .temp_sample(temp_s), .monitor_flags(mon), .miso(miso),
      .miso_oe(miso_oe), .parity_enable(parity_enable), .parity_sense_select(parity_sense_select));

   gdr_host_model host_u (.ref_clk(ref_clk), .miso(miso), .sck(sck),
      .rate_chip_select_n(rate_chip_select_n), .mosi(mosi));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // ***************************************************************
   // Expected values
   // ***************************************************************
   function automatic logic [15:0] dword(input logic [13:0] s);
      logic ok;
      ok = (&mon) & pok;
      dword = {s, ok, ~^{s[12:0], ok}};
   endfunction

   function automatic logic [15:0] flags();
      logic s;
      s = (&mon) & pok;
      flags = {14'h0000, s, ~s};
   endfunction

   function automatic logic [15:0] aw(input logic [6:0] a, input logic rw);
      aw = {6'h00, a, rw, 1'b0, ~^{a, rw}};
   endfunction

   function automatic logic [15:0] exp_reg(input logic [6:0] a);
      case (a)
         GDR_ADR_RATE: exp_reg = dword(rate_s);
         GDR_ADR_IDENT: exp_reg = {2'b00, sel, en, 12'h000};
         GDR_ADR_STATUS: exp_reg = {mon[12:7], pok, mon[6:0], 2'b00};
         GDR_ADR_TEMP: exp_reg = dword(temp_s);
         default: exp_reg = 16'h0000;
      endcase
   endfunction

   // ***************************************************************
   // Transfers
   // ***************************************************************
   task automatic send(input logic [15:0] w, input logic flip, output logic [15:0] r);
      logic [16:0] raw;
      host_u.xword(w, en, sel, flip, raw);
      if (en) begin
         r = raw[16:1];
         `CHK("reply parity", (sel ? ~^raw[16:1] : ^raw[16:1]), raw[0])
      end else begin
         r = raw[15:0];
      end
   endtask

   // fl corrupts the parity of the first address word
   task automatic reads(input string nm, input logic fl = 1'b0);
      logic [15:0] r;
      logic [15:0] ex;
      host_u.open_cs();
      `CHK("select enable", 1'b1, miso_oe)
      send(aw(aq[0], 1'b0), fl, r);
      `CHK("flags word", flags(), r)
      for (int i = 1; i <= aq.size(); i++) begin
         ex = exp_reg(aq[i-1]);
         if (aq[i-1] == GDR_ADR_STATUS) begin
            pok = 1'b1;
         end
         // A parity error in the same address word wins over the clear
         if ((i == 1) && fl && en) begin
            pok = 1'b0;
         end
         send(i < aq.size() ? aw(aq[i], 1'b0) : 16'h0000, 1'b0, r);
         `CHK("read word", ex, r)
      end
      host_u.close_cs();
      `CHK("select released", 1'b0, miso_oe)
      $display("test %s done", nm);
   endtask

   task automatic wr_ident(input logic e_n, input logic s_n, input logic fa, input logic fd);
      logic [15:0] r;
      logic [15:0] ef;
      host_u.open_cs();
      send(aw(GDR_ADR_IDENT, 1'b1), fa, r);
      `CHK("flags word", flags(), r)
      // An address error drops the flag before the data word ends
      if (en && fa) begin
         pok = 1'b0;
      end
      // Only the two configuration bits are ever set by the host
      send({2'b00, s_n, e_n, 12'h000}, fd, r);
      `CHK("write echo", exp_reg(GDR_ADR_IDENT), r)
      // Flags for the next word are taken as the data word ends, before a data error lands
      ef = flags();
      if (en && (fa || fd)) begin
         pok = 1'b0;
      end else begin
         en = e_n;
         sel = s_n;
      end
      // New frame length and sense apply from the word after the data word
      send(aw(GDR_ADR_IDENT, 1'b0), 1'b0, r);
      `CHK("flags after write", ef, r)
      send(16'h0000, 1'b0, r);
      `CHK("ident readback", exp_reg(GDR_ADR_IDENT), r)
      host_u.close_cs();
      `CHK("parity enable pin", en, parity_enable)
      `CHK("parity sense pin", sel, parity_sense_select)
      $display("test write ident done");
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge ref_clk);
      $display("unexpected run length expected done seen hang");
      bad_count++;
      finish_test();
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      rst_n = 1'b0;
      rate_s = 14'h2000;
      temp_s = 14'h1fff;
      mon = 13'h1fff;
      pok = 1'b1;
      en = 1'b0;
      sel = 1'b0;
      bad_count = 0;
      comparisons = 0;
      aq = '{7'h00, 7'h01, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h7f};
      void'($urandom(30));
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (5) @(negedge ref_clk);
      `CHK("enable after reset", 1'b0, parity_enable)
      `CHK("sense after reset", 1'b0, parity_sense_select)
      reads("corner sweep");
      // Every enable and sense combination, twice, each followed by a full sweep
      for (int k = 0; k < 8; k++) begin
         wr_ident(k[0], k[1], 1'b0, 1'b0);
         rate_s = 14'($urandom);
         temp_s = 14'($urandom);
         mon = ($urandom_range(0, 1) == 0) ? 13'h1fff : 13'($urandom);
         if (k == 2) begin
            mon = 13'h1fbf;
         end
         reads("random sweep");
      end
      mon = 13'h1fff;
      wr_ident(1'b0, 1'b0, 1'b0, 1'b1);
      aq = '{GDR_ADR_STATUS, GDR_ADR_STATUS, GDR_ADR_RATE};
      reads("status after data error");
      wr_ident(1'b0, 1'b0, 1'b1, 1'b0);
      reads("status after address error");
      reads("read with address error", 1'b1);
      wr_ident(1'b0, 1'b1, 1'b0, 1'b0);
      reads("parity off");
      finish_test();
   end
endmodule
`default_nettype wire
